// [src/sir_pkg.sv]
// constants and types for the start-initiated auto-recloser
// =====================================================================
// Summary of operation
// - starter pickup raises pending, first shot, counts start
// - start time over: running on, open breaker
// - breaker open, starter released: count dead time
// - dead time over: send close request
// - hold close until closed, then start reclaim
// - starter pickup in reclaim runs arcing timer too
// - arcing expired: open, move to next shot
// - next shot: count its dead time, then close
// - request during reclaim advances to next shot once arcing time is reached
// - no shot left: final trip, clear flags, lock
// - reclaim expired quietly: clear flags, general reclaim
// - fault in general reclaim may lock, by setting
// - zero general reclaim time is skipped
// - setting omits general reclaim after success
// - general reclaim expired: back to ready
// - stage operate time exceeds start and arcing
// - manual open or close resets the sequence; manual close in dead time locks
package sir_pkg;
    // =================================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int unsigned TIME_W = 24;
    // =================================================================
    // register map (byte addresses)
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFF_GEN_RECLAIM = 8'h10;
    localparam logic [7:0] OFF_SHOT_EN = 8'h14;
    localparam logic [7:0] OFF_SHOT_BASE = 8'h20;
    localparam logic [7:0] SHOT_STRIDE = 8'h10;
    localparam logic [7:0] FIELD_STRIDE = 8'h04;
    // per-shot timer fields
    localparam int unsigned T_START = 0;
    localparam int unsigned T_DEAD = 1;
    localparam int unsigned T_ARC = 2;
    localparam int unsigned T_RECLAIM = 3;
    // control bits
    localparam int unsigned CTRL_ENABLE = 0;
    localparam int unsigned CTRL_GR_LOCK = 1;
    localparam int unsigned CTRL_GR_OMIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h3;
    // status bits
    localparam int unsigned ST_PEND = 0;
    localparam int unsigned ST_ACTIVE = 1;
    localparam int unsigned ST_GR = 2;
    localparam int unsigned ST_LOCK = 3;
    localparam int unsigned ST_OPEN = 4;
    localparam int unsigned ST_CLOSE = 5;
    localparam int unsigned ST_SHOT_LSB = 8;
    localparam int unsigned ST_RUN_LSB = 16;
    // interrupt events
    localparam int unsigned EV_W = 5;
    localparam int unsigned EV_START = 0;
    localparam int unsigned EV_OPEN = 1;
    localparam int unsigned EV_CLOSE = 2;
    localparam int unsigned EV_LOCK = 3;
    localparam int unsigned EV_DONE = 4;
    localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
    // =================================================================
    // reset values of the timers, milliseconds
    localparam logic [23:0] DEF_START_MS = 24'h0001F4;
    localparam logic [23:0] DEF_DEAD1_MS = 24'h0000C8;
    localparam logic [23:0] DEF_DEAD2_MS = 24'h01D4C0;
    localparam logic [23:0] DEF_ARC_MS = 24'h0000C8;
    localparam logic [23:0] DEF_RECLAIM_MS = 24'h002710;
    localparam logic [23:0] DEF_GEN_RECLAIM_MS = 24'h002710;

    // default of one timer of one shot; later shots copy the second
    function automatic logic [23:0] sir_default(input int unsigned shot,
                                                input int unsigned field);
        logic [23:0] v;
        v = DEF_START_MS;
        if (field == T_DEAD) begin
            v = (shot == 0) ? DEF_DEAD1_MS : DEF_DEAD2_MS;
        end else if (field == T_ARC) begin
            v = DEF_ARC_MS;
        end else if (field == T_RECLAIM) begin
            v = DEF_RECLAIM_MS;
        end
        return v;
    endfunction

    // sequence states
    typedef enum logic [3:0] {
        SIR_READY,
        SIR_START,
        SIR_OPEN_WAIT,
        SIR_DEAD,
        SIR_CLOSE_WAIT,
        SIR_RECLAIM,
        SIR_GEN_RECLAIM,
        SIR_LOCKED
    } sir_state_t;
endpackage

// [src/sir_recloser.sv]
// shot sequencer of the start-initiated auto-recloser
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sir_recloser
    import sir_pkg::*;
#(
    parameter int unsigned NUM_SHOTS = 2,
    parameter int unsigned CYC_MS = CYC_PER_MS
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic reclose_request_one,
    input wire logic breaker_open,
    input wire logic breaker_closed,
    input wire logic manual_open,
    input wire logic manual_close,
    output logic open_cmd,
    output logic close_cmd,
    output logic request_one_pending,
    output logic first_shot_active,
    output logic second_shot_active,
    output logic recloser_active,
    output logic general_reclaim_active,
    output logic recloser_locked,
    output logic irq
);
    // =================================================================
    // state
    localparam int unsigned SHOT_W = $clog2(NUM_SHOTS);
    localparam int unsigned PRE_W = $clog2(CYC_MS + 1);

    typedef struct packed {
        sir_state_t fsm; // sequence state
        logic [PRE_W-1:0] pre; // ms prescaler
        logic [TIME_W-1:0] cnt; // state timer, ms
        logic [TIME_W-1:0] arc; // cumulative arcing, ms
        logic [SHOT_W-1:0] shot; // current shot
        logic [NUM_SHOTS-1:0] run; // shot running flags
        logic pend; // request pending
        logic active; // recloser running
        logic gr; // general reclaim
        logic lock; // locked out
        logic open; // open command
        logic close; // close command
        logic [2:0] ctrl; // control setting
        logic [NUM_SHOTS-1:0] shot_en; // configured shots
        logic [TIME_W-1:0] gr_time; // general reclaim, ms
        logic [NUM_SHOTS-1:0][3:0][TIME_W-1:0] tset; // per-shot timers
        logic [EV_W-1:0] irq_stat; // sticky events
        logic [EV_W-1:0] irq_mask; // event enables
        logic [DATA_W-1:0] rdata; // read answer
    } sir_regs_t;

    sir_regs_t st;
    sir_regs_t next_st;
    logic tick; // one-cycle ms pulse
    logic [3:0][TIME_W-1:0] cur; // timers of current shot
    logic [SHOT_W-1:0] next_shot; // shot after current
    logic has_next; // a further shot is configured
    logic [EV_W-1:0] ev; // events of this cycle
    logic [DATA_W-1:0] status; // status word
    logic [DATA_W-1:0] rd_val; // decoded read value
    logic in_seq; // sequence in progress

    // =================================================================
    // next-state logic
    always_comb begin
        next_st = st;
        ev = '0;
        tick = (st.pre == PRE_W'(CYC_MS - 1));
        next_st.pre = tick ? '0 : st.pre + 1'b1;
        if (tick && (st.cnt != '1)) begin
            next_st.cnt = st.cnt + 1'b1;
        end
        cur = st.tset[st.shot];
        next_shot = st.shot + 1'b1;
        has_next = (32'(st.shot) < NUM_SHOTS - 1) && st.shot_en[next_shot];
        in_seq = (st.fsm == SIR_START) || (st.fsm == SIR_OPEN_WAIT) ||
                 (st.fsm == SIR_DEAD) || (st.fsm == SIR_CLOSE_WAIT) ||
                 (st.fsm == SIR_RECLAIM);

        // --- manual breaker operation cancels a running sequence
        if (in_seq && (manual_open || manual_close)) begin
            next_st.pend = 1'b0;
            next_st.active = 1'b0;
            next_st.run = '0;
            next_st.open = 1'b0;
            next_st.close = 1'b0;
            next_st.cnt = '0;
            // manual close in dead time locks
            if (manual_close && (st.fsm == SIR_DEAD)) begin
                next_st.lock = 1'b1;
                next_st.fsm = SIR_LOCKED;
                ev[EV_LOCK] = 1'b1;
            end else begin
                next_st.fsm = SIR_READY;
            end
        end else begin
            case (st.fsm)
                // waiting for a starter pickup
                SIR_READY, SIR_GEN_RECLAIM: begin
                    if (reclose_request_one && st.ctrl[CTRL_ENABLE] && st.shot_en[0]) begin
                        if ((st.fsm == SIR_GEN_RECLAIM) && st.ctrl[CTRL_GR_LOCK]) begin
                            next_st.gr = 1'b0;
                            next_st.open = 1'b1;
                            next_st.lock = 1'b1;
                            next_st.fsm = SIR_LOCKED;
                            ev[EV_LOCK] = 1'b1;
                        end else begin
                            next_st.gr = 1'b0;
                            next_st.pend = 1'b1;
                            next_st.shot = '0;
                            next_st.run = NUM_SHOTS'(1);
                            next_st.cnt = '0;
                            next_st.arc = '0;
                            next_st.fsm = SIR_START;
                            ev[EV_START] = 1'b1;
                        end
                    end else if ((st.fsm == SIR_GEN_RECLAIM) && (st.cnt >= st.gr_time)) begin
                        next_st.gr = 1'b0;
                        next_st.fsm = SIR_READY;
                    end
                end
                // counting the start time of the first shot
                SIR_START: begin
                    if (!reclose_request_one) begin
                        // starter dropped before start time ended
                        next_st.pend = 1'b0;
                        next_st.run = '0;
                        next_st.fsm = SIR_READY;
                    end else if (st.cnt >= cur[T_START]) begin
                        next_st.active = 1'b1;
                        next_st.open = 1'b1;
                        next_st.fsm = SIR_OPEN_WAIT;
                        ev[EV_OPEN] = 1'b1;
                    end
                end
                // open command out, waiting for open and release
                SIR_OPEN_WAIT: begin
                    if (breaker_open) begin
                        next_st.open = 1'b0;
                    end
                    // dead time after open and release
                    if (breaker_open && !reclose_request_one) begin
                        next_st.cnt = '0;
                        next_st.fsm = SIR_DEAD;
                    end
                end
                // dead time of current shot
                SIR_DEAD: begin
                    if (st.cnt >= cur[T_DEAD]) begin
                        next_st.close = 1'b1;
                        next_st.fsm = SIR_CLOSE_WAIT;
                        ev[EV_CLOSE] = 1'b1;
                    end
                end
                // close command held until breaker closed
                SIR_CLOSE_WAIT: begin
                    if (breaker_closed) begin
                        next_st.close = 1'b0;
                        next_st.cnt = '0;
                        next_st.arc = '0;
                        next_st.fsm = SIR_RECLAIM;
                    end
                end
                // reclaim and arcing of current shot
                SIR_RECLAIM: begin
                    // arcing counts while starter is up
                    if (reclose_request_one && tick && (st.arc != '1)) begin
                        next_st.arc = st.arc + 1'b1;
                    end
                    if (reclose_request_one && (st.arc >= cur[T_ARC])) begin
                        next_st.open = 1'b1;
                        next_st.cnt = '0;
                        ev[EV_OPEN] = 1'b1;
                        if (has_next) begin
                            next_st.shot = next_shot;
                            next_st.run = NUM_SHOTS'(1) << next_shot;
                            next_st.fsm = SIR_OPEN_WAIT;
                        end else begin
                            next_st.pend = 1'b0;
                            next_st.active = 1'b0;
                            next_st.run = '0;
                            next_st.lock = 1'b1;
                            next_st.fsm = SIR_LOCKED;
                            ev[EV_LOCK] = 1'b1;
                        end
                    end else if (!reclose_request_one && (st.cnt >= cur[T_RECLAIM])) begin
                        next_st.pend = 1'b0;
                        next_st.active = 1'b0;
                        next_st.run = '0;
                        next_st.cnt = '0;
                        ev[EV_DONE] = 1'b1;
                        if (st.ctrl[CTRL_GR_OMIT] || (st.gr_time == '0)) begin
                            next_st.fsm = SIR_READY;
                        end else begin
                            next_st.gr = 1'b1;
                            next_st.fsm = SIR_GEN_RECLAIM;
                        end
                    end
                end
                // locked out until the operator closes the breaker
                SIR_LOCKED: begin
                    if (breaker_open) begin
                        next_st.open = 1'b0;
                    end
                    if (manual_close) begin
                        next_st.lock = 1'b0;
                        next_st.open = 1'b0;
                        next_st.fsm = SIR_READY;
                    end
                end
                default: begin
                    next_st.fsm = SIR_READY;
                end
            endcase
        end

        // --- status word
        status = '0;
        status[ST_PEND] = st.pend;
        status[ST_ACTIVE] = st.active;
        status[ST_GR] = st.gr;
        status[ST_LOCK] = st.lock;
        status[ST_OPEN] = st.open;
        status[ST_CLOSE] = st.close;
        status[ST_SHOT_LSB +: SHOT_W] = st.shot;
        status[ST_RUN_LSB +: NUM_SHOTS] = st.run;

        // --- read decode
        rd_val = '0;
        if (reg_addr == OFF_CTRL) begin
            rd_val[2:0] = st.ctrl;
        end else if (reg_addr == OFF_STATUS) begin
            rd_val = status;
        end else if (reg_addr == OFF_IRQ_STAT) begin
            rd_val[EV_W-1:0] = st.irq_stat;
        end else if (reg_addr == OFF_IRQ_MASK) begin
            rd_val[EV_W-1:0] = st.irq_mask;
        end else if (reg_addr == OFF_GEN_RECLAIM) begin
            rd_val[TIME_W-1:0] = st.gr_time;
        end else if (reg_addr == OFF_SHOT_EN) begin
            rd_val[NUM_SHOTS-1:0] = st.shot_en;
        end
        for (int s = 0; s < NUM_SHOTS; s++) begin
            for (int f = 0; f < 4; f++) begin
                if (reg_addr == OFF_SHOT_BASE + 8'(s) * SHOT_STRIDE + 8'(f) * FIELD_STRIDE) begin
                    rd_val[TIME_W-1:0] = st.tset[s][f];
                end
            end
        end
        // answer stands only in the cycle after the strobe
        next_st.rdata = reg_rd ? rd_val : '0;

        // --- register writes; unmapped addresses are ignored
        if (reg_wr) begin
            if (reg_addr == OFF_CTRL) begin
                next_st.ctrl = reg_wdata[2:0];
            end else if (reg_addr == OFF_IRQ_MASK) begin
                next_st.irq_mask = reg_wdata[EV_W-1:0];
            end else if (reg_addr == OFF_GEN_RECLAIM) begin
                next_st.gr_time = reg_wdata[TIME_W-1:0];
            end else if (reg_addr == OFF_SHOT_EN) begin
                next_st.shot_en = reg_wdata[NUM_SHOTS-1:0];
            end
            for (int s = 0; s < NUM_SHOTS; s++) begin
                for (int f = 0; f < 4; f++) begin
                    if (reg_addr == OFF_SHOT_BASE + 8'(s) * SHOT_STRIDE +
                            8'(f) * FIELD_STRIDE) begin
                        next_st.tset[s][f] = reg_wdata[TIME_W-1:0];
                    end
                end
            end
        end

        // --- sticky events: read clears, a new event wins
        if (reg_rd && (reg_addr == OFF_IRQ_STAT)) begin
            next_st.irq_stat = ev;
        end else begin
            next_st.irq_stat = st.irq_stat | ev;
        end
    end

    // =================================================================
    // state register with synchronous reset
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st <= '0;
            st.fsm <= SIR_READY;
            st.ctrl <= CTRL_RESET;
            st.shot_en <= '1;
            st.gr_time <= DEF_GEN_RECLAIM_MS;
            st.irq_mask <= IRQ_MASK_RESET;
            for (int s = 0; s < NUM_SHOTS; s++) begin
                for (int f = 0; f < 4; f++) begin
                    st.tset[s][f] <= sir_default(s, f);
                end
            end
        end else begin
            st <= next_st;
        end
    end

    // =================================================================
    // outputs
    assign reg_rdata = st.rdata;
    assign open_cmd = st.open;
    assign close_cmd = st.close;
    assign request_one_pending = st.pend;
    assign first_shot_active = st.run[0];
    assign second_shot_active = st.run[1];
    assign recloser_active = st.active;
    assign general_reclaim_active = st.gr;
    assign recloser_locked = st.lock;
    assign irq = |(st.irq_stat & st.irq_mask);
endmodule
`default_nettype wire

// [verif/sir_breaker.sv]
// breaker and object control model that follows the recloser commands
`timescale 1ns/1ps
`default_nettype none
module sir_breaker (
    input wire logic sys_clk,
    input wire logic open_cmd,
    input wire logic close_cmd,
    input wire logic manual_close,
    input wire logic [3:0] dly,
    output logic breaker_open,
    output logic breaker_closed
);
    // =================================================================
    // position, high when closed, and travel count in cycles
    logic pos = 1'h1;
    logic [3:0] cnt = 4'h0;
    // close on request or by the operator, open on command
    always @(posedge sys_clk) begin
        if ((open_cmd && pos) || ((close_cmd || manual_close) && !pos)) begin
            cnt <= cnt + 4'h1;
            if (cnt >= dly) begin
                pos <= !pos;
                cnt <= 4'h0;
            end
        end else begin
            cnt <= 4'h0;
        end
    end
    // both position contacts are always driven
    assign breaker_open = !pos;
    assign breaker_closed = pos;
endmodule
`default_nettype wire

// [verif/sir_recloser_chk.sv]
// port assertions for the recloser sequencer
`timescale 1ns/1ps
`default_nettype none
module sir_recloser_chk (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic breaker_closed,
    input wire logic manual_open,
    input wire logic manual_close,
    input wire logic open_cmd,
    input wire logic close_cmd,
    input wire logic request_one_pending,
    input wire logic first_shot_active,
    input wire logic second_shot_active,
    input wire logic recloser_active,
    input wire logic general_reclaim_active,
    input wire logic recloser_locked
);
    // =================================================================
    // one clock domain, checks idle in reset
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // operator action and the sequence flags
    wire logic man = manual_open | manual_close;
    wire logic [3:0] seq_flags = {recloser_active, request_one_pending,
        first_shot_active, second_shot_active};
    pend_first_a: assert property (
        $rose(request_one_pending) |-> first_shot_active && !recloser_active)
        else $error("pending rose without first shot");
    run_open_a: assert property ($rose(recloser_active) |-> open_cmd)
        else $error("run started without open");
    close_hold_a: assert property (close_cmd && !breaker_closed && !man |=> close_cmd)
        else $error("close dropped before closed");
    close_drop_a: assert property (close_cmd && breaker_closed |-> ##[1:2] !close_cmd)
        else $error("close held after closed");
    shot_two_a: assert property (
        $rose(second_shot_active) |-> open_cmd && !first_shot_active)
        else $error("second shot without open");
    lock_clear_a: assert property (recloser_locked |-> seq_flags == 4'h0)
        else $error("flags set in lock-out");
    lock_hold_a: assert property (recloser_locked && !man |=> recloser_locked)
        else $error("lock-out left alone");
    gr_clear_a: assert property (general_reclaim_active |-> seq_flags == 4'h0)
        else $error("flags set in general reclaim");
    // main scenarios reached
    cover property ($rose(second_shot_active));
    cover property ($rose(recloser_locked));
    cover property ($fell(general_reclaim_active) && !recloser_locked);
endmodule
bind sir_recloser sir_recloser_chk sir_recloser_chk_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .breaker_closed(breaker_closed), .manual_open(manual_open), .manual_close(manual_close),
    .open_cmd(open_cmd), .close_cmd(close_cmd), .request_one_pending(request_one_pending),
    .first_shot_active(first_shot_active), .second_shot_active(second_shot_active),
    .recloser_active(recloser_active), .general_reclaim_active(general_reclaim_active),
    .recloser_locked(recloser_locked));
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the start-initiated recloser
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sir_pkg::*;
    localparam int CM = 10;
    logic sys_clk = 1'h0, reset_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, req = 1'h0;
    logic mo = 1'h0, mc = 1'h0, open_cmd, close_cmd, pend, s1, s2, act, gr, lock, irq, bo, bc;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, ev = 32'h0;
    logic [3:0] dly = 4'h2;
    int seed = 35, mismatches = 0, n_compared = 0, cyc = 0, i, n;
    int evq[$] = '{EV_START, EV_OPEN, EV_CLOSE, EV_LOCK};
    logic [7:0] ra [5] = '{OFF_CTRL, OFF_IRQ_MASK, OFF_GEN_RECLAIM, 8'h34, 8'hFC};
    logic [31:0] rv [5] = '{32'h3, 32'h0, 32'(DEF_GEN_RECLAIM_MS), 32'(DEF_DEAD2_MS), 32'h0};
    logic [31:0] tm [4] = '{32'h5, 32'h3, 32'h4, 32'h6};
    // irq, breaker open, close, open, lock, general reclaim, run, shot2, shot1, pending
    wire logic [9:0] obs = {irq, bo, close_cmd, open_cmd, lock, gr, act, s2, s1, pend};
    // =================================================================
    // design, breaker model and clock
    sir_recloser #(.CYC_MS(CM)) sir_recloser_i (.sys_clk(sys_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reclose_request_one(req), .breaker_open(bo), .breaker_closed(bc),
        .manual_open(mo), .manual_close(mc), .open_cmd(open_cmd), .close_cmd(close_cmd),
        .request_one_pending(pend), .first_shot_active(s1), .second_shot_active(s2),
        .recloser_active(act), .general_reclaim_active(gr), .recloser_locked(lock), .irq(irq));
    sir_breaker sir_breaker_i (.sys_clk(sys_clk), .open_cmd(open_cmd), .close_cmd(close_cmd),
        .manual_close(mc), .dly(dly), .breaker_open(bo), .breaker_closed(bc));
    initial forever #50 sys_clk = ~sys_clk;
    // mismatch report
    task automatic bad(input string s);
        mismatches++;
        $display("BAD %0t %s", $time, s);
    endtask
    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
    endtask
    // register read, data compared in the cycle after the strobe
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_addr <= a; reg_rd <= 1'h1;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        @(negedge sys_clk);
        n_compared++;
        if (reg_rdata !== e) bad("register value");
    endtask
    // masked compare of the observed outputs
    task automatic chk(input logic [9:0] e, input logic [9:0] m);
        n_compared++;
        if ((obs & m) !== e) bad("output flags");
    endtask
    // measured cycles against a millisecond setting
    task automatic chk_time(input int k, input int ms);
        n_compared++;
        if (k < (ms - 1) * CM || k > ms * CM + 6) bad("timer length");
    endtask
    // bounded wait for one observed bit, counting cycles
    task automatic wt(input int b, input logic v, output int k);
        k = 0;
        @(negedge sys_clk);
        while (obs[b] !== v && k < 3000) begin
            @(negedge sys_clk);
            k++;
        end
        if (k == 3000) bad("no response");
    endtask
    // starter pickup up to the first open command
    task automatic start_seq;
        int k;
        dly = 4'(2 + ($random(seed) & 3));
        @(posedge sys_clk);
        req <= 1'h1;
        repeat (2) @(negedge sys_clk);
        chk(10'h003, 10'h04F);
        wt(6, 1'h1, k);
        chk_time(k + 3, 5);
        chk(10'h04B, 10'h04F);
    endtask
    // starter release, dead time, reclose; fault picks up again if f
    task automatic reclose(input logic f);
        int k;
        wt(8, 1'h1, k);
        @(posedge sys_clk);
        req <= 1'h0;
        wt(7, 1'h1, k);
        chk_time(k, 3);
        wt(7, 1'h0, k);
        chk(10'h000, 10'h180);
        if (f) begin
            @(posedge sys_clk);
            req <= 1'h1;
            wt(6, 1'h1, k);
            chk_time(k, 4);
        end
    endtask
    // operator closes the breaker, sequence back to ready
    task automatic unlock;
        int k;
        @(posedge sys_clk);
        req <= 1'h0; mc <= 1'h1;
        // held until the breaker has travelled shut
        repeat (8) @(posedge sys_clk);
        mc <= 1'h0;
        wt(5, 1'h0, k);
        chk(10'h000, 10'h13F);
    endtask
    // verdict
    task automatic close_out;
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad("timeout");
            close_out;
        end
    end
    // =================================================================
    // main sequence
    initial begin
        foreach (evq[j]) ev[evq[j]] = 1'h1;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'h1;
        for (i = 0; i < 5; i++) chk_reg(ra[i], rv[i]);
        for (i = 0; i < 8; i++) wr(8'(32 + i * 4), tm[i % 4]);
        wr(OFF_GEN_RECLAIM, 32'h5);
        wr(OFF_IRQ_MASK, 32'h8);
        // both shots fail, lock-out follows
        start_seq;
        reclose(1'h1);
        chk(10'h04D, 10'h24F);
        reclose(1'h1);
        repeat (2) @(negedge sys_clk);
        chk(10'h220, 10'h23F);
        wt(8, 1'h1, n);
        repeat (20) @(negedge sys_clk);
        chk(10'h020, 10'h02F);
        chk_reg(OFF_IRQ_STAT, ev);
        chk(10'h000, 10'h200);
        chk_reg(OFF_IRQ_STAT, 32'h0);
        unlock;
        // first shot succeeds, general reclaim runs out, then a fault inside it
        for (i = 0; i < 2; i++) begin
            start_seq;
            reclose(1'h0);
            wt(4, 1'h1, n);
            chk_time(n, 6);
            chk(10'h010, 10'h01F);
            @(posedge sys_clk);
            req <= 1'(i);
            wt(i ? 5 : 4, 1'(i), n);
            chk_time(n, i ? 0 : 5);
            if (i) wt(8, 1'h1, n);
            unlock;
        end
        // general reclaim omitted, then zero general reclaim skipped
        for (i = 0; i < 2; i++) begin
            wr(OFF_CTRL, i ? 32'h3 : 32'h5);
            wr(OFF_GEN_RECLAIM, i ? 32'h0 : 32'h5);
            start_seq;
            reclose(1'h0);
            wt(3, 1'h0, n);
            chk_time(n, 6);
            repeat (3) @(negedge sys_clk);
            chk(10'h000, 10'h03F);
        end
        // manual open, then manual close, during dead time
        for (i = 0; i < 2; i++) begin
            start_seq;
            wt(8, 1'h1, n);
            @(posedge sys_clk);
            req <= 1'h0;
            repeat (5) @(posedge sys_clk);
            mo <= 1'(!i); mc <= 1'(i);
            @(posedge sys_clk);
            mo <= 1'h0; mc <= 1'h0;
            repeat (60) @(negedge sys_clk);
            chk(i ? 10'h020 : 10'h000, 10'h0BF);
            unlock;
        end
        close_out;
    end
endmodule
`default_nettype wire
